// File: shared/flame_pkg.sv
// Constants for the flame supervision block: phase codes, lockout codes,
// setting encodings and timing.
// Assumes the sequencer reports its current phase number on every clock.
//
// Summary of operation
// - Detector test output inactive during prepurge
// - Detector test output active from first safety time
// - Detector self-test at shutdown start, fault locks 31
// - Restart setting: 0,1 none; 2..4 one to three
// - Flame loss in operation: restarts, then lockout
// - Restart after loss needs flame at safety end
// - No flame at safety end: configured restarts allowed
// - Channel setting 0 is OR, 1 is AND
// - OR mode: any channel after phase 42, else 2
// - AND mode: any channel phases 42 to 50
// - AND mode after phase 50: both, else 7
// - Extraneous light in phase 30 locks with 4
// - Standby light: LED, indication, timeout locks 4
// - Standby tolerance 0 to 2047 s, default 30
// - Analog selector decodes six load input types
// - Selector 0: load from contact inputs only
// - Load inputs acted on only in operation
// - Display mode selects phase, flames or power
// - Combustion mode 1 forces lockout
// - Flame-out within 1 s or 2 s plus extension

package flame_pkg;

    // ----------------------------------------
    // Phase numbers
    // ----------------------------------------
    localparam logic [7:0] PH_STANDBY = 8'h0c;
    localparam logic [7:0] PH_PREPURGE = 8'h18;
    localparam logic [7:0] PH_STRAY = 8'h1e;
    localparam logic [7:0] PH_SAFETY1 = 8'h2a;
    localparam logic [7:0] PH_INTERVAL = 8'h2c;
    localparam logic [7:0] PH_SAFETY2 = 8'h32;
    localparam logic [7:0] PH_OPERATE = 8'h3c;
    localparam logic [7:0] PH_SHUTDOWN = 8'h0a;

    // ----------------------------------------
    // Lockout codes and setting encodings
    // ----------------------------------------
    localparam logic [7:0] LOC_NO_FLAME = 8'h02;
    localparam logic [7:0] LOC_STRAY = 8'h04;
    localparam logic [7:0] LOC_AND = 8'h07;
    localparam logic [7:0] LOC_SELFTEST = 8'h1f;
    localparam logic [7:0] LOC_ANALOG = 8'h3c;
    localparam logic [7:0] LOC_COMB = 8'h0f;
    localparam logic [1:0] COMB_UNUSED = 2'h1;
    localparam logic [2:0] AIN_STEP = 3'h0;
    localparam logic [2:0] AIN_4_20_LOCK = 3'h4;
    localparam logic [2:0] AIN_LAST = 3'h5;
    localparam logic [2:0] DISP_IONIZATION = 3'h2;
    localparam logic [2:0] DISP_DETECTOR = 3'h3;
    localparam logic [2:0] DISP_POWER = 3'h4;
    localparam logic [10:0] TOLERANCE_DEFAULT_S = 11'h01e;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int IONIZATION_OUT_MS = 1000;
    localparam int DETECTOR_OUT_MS = 2000;
    localparam logic [9:0] MS_PER_S_LAST = 10'h3e7;
    localparam logic [6:0] SELFTEST_MS_LAST = 7'h63;

    typedef enum logic [1:0] {
        TST_IDLE = 2'b00,
        TST_RUN = 2'b01,
        TST_DONE = 2'b10
    } test_state_type;

    function automatic logic [1:0] restart_allow(input logic [2:0] s);
        case (s)
            3'h2: restart_allow = 2'h1;
            3'h3: restart_allow = 2'h2;
            3'h4: restart_allow = 2'h3;
            default: restart_allow = 2'h0;
        endcase
    endfunction: restart_allow

endpackage: flame_pkg

// File: hdl/ms_tick.sv
// Millisecond tick generator.
// Assumes a single clock; the period in cycles is set from the top.
`timescale 1ns/1ps
module ms_tick #(
    parameter int CYCLES = flame_pkg::MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o
);
    logic [17:0] cnt_ff;
    logic wrap;

    assign wrap = cnt_ff == 18'(CYCLES - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 18'h0_0000;
            tick_o <= 1'b0;
        end else begin
            cnt_ff <= wrap ? 18'h0_0000 : cnt_ff + 18'h0_0001;
            tick_o <= wrap;
        end
    end
endmodule: ms_tick

// File: hdl/flame_out_filter.sv
// Flame-out response filter for one flame channel.
// Assumes a millisecond tick; flame-on passes at once.
`timescale 1ns/1ps
module flame_out_filter #(
    parameter int BASE_MS = flame_pkg::IONIZATION_OUT_MS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic raw_i,
    input wire logic [11:0] ext_ms_i,
    output logic flame_o
);
    logic [12:0] cnt_ff;
    logic [12:0] limit;
    logic expire;

    // Base response time plus the configured extension
    assign limit = 13'(BASE_MS) + {1'b0, ext_ms_i};
    assign expire = cnt_ff + 13'h0001 >= limit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 13'h0000;
            flame_o <= 1'b0;
        end else if (raw_i) begin
            cnt_ff <= 13'h0000;
            flame_o <= 1'b1;
        end else if (tick_i && flame_o) begin
            cnt_ff <= expire ? 13'h0000 : cnt_ff + 13'h0001;
            flame_o <= !expire;
        end
    end
endmodule: flame_out_filter

// File: hdl/flame_supervision_logic.sv
// Flame supervision, restart limiting, extraneous light timing,
// detector self-test, load input selection and display selection.
// Assumes phase, settings and flame inputs are synchronous to MCLK_I.
`timescale 1ns/1ps
module flame_supervision_logic #(
    parameter int MS_CYCLES = flame_pkg::MS_CYCLES
) (
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic [7:0] PHASE_I,
    input wire logic HEAT_REQ_I,
    input wire logic IONIZATION_FLAME_I,
    input wire logic DET_FLAME_I,
    input wire logic DET_FAULT_I,
    input wire logic COMBINE_AND_I,
    input wire logic [2:0] RESTART_SET_I,
    input wire logic [11:0] EXT_DELAY_MS_I,
    input wire logic [10:0] TOLERANCE_S_I,
    input wire logic [1:0] COMB_MODE_I,
    input wire logic [2:0] ANALOG_SEL_I,
    input wire logic [11:0] ANALOG_VALUE_I,
    input wire logic ANALOG_LOW_I,
    input wire logic LOAD_CLOSE_I,
    input wire logic LOAD_OPEN_I,
    input wire logic [2:0] DISPLAY_MODE_I,
    input wire logic [7:0] IONIZATION_LEVEL_I,
    input wire logic [7:0] DET_LEVEL_I,
    input wire logic [7:0] POWER_I,
    output logic DET_TEST_O,
    output logic LOCKOUT_O,
    output logic [7:0] LOCK_CODE_O,
    output logic RESTART_O,
    output logic STRAY_LED_O,
    output logic STANDBY_STRAY_LIGHT_INDICATION_O,
    output logic LOAD_DOWN_O,
    output logic LOAD_UP_O,
    output logic [11:0] LOAD_VALUE_O,
    output logic LOAD_VALID_O,
    output logic [7:0] DISPLAY_O
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic tick;
    logic ion_fl;
    logic det_fl;
    logic [7:0] phase_prev_ff;
    logic heat_prev_ff;
    logic [1:0] used_ff;
    logic from_loss_ff;
    logic pend_ff;
    logic [9:0] sb_ms_ff;
    logic [10:0] sb_sec_ff;
    logic [6:0] tst_ms_ff;
    flame_pkg::test_state_type tst_ff;
    flame_pkg::test_state_type nxt_tst;
    logic in_standby;
    logic in_prepurge;
    logic in_stray;
    logic in_mid;
    logic in_oper;
    logic in_shut;
    logic test_region;
    logic end_s1;
    logic shut_entry;
    logic heat_fall;
    logic live;
    logic raw_any;
    logic any_fl;
    logic both_fl;
    logic need_both;
    logic flame_short;
    logic [1:0] allow;
    logic can_restart;
    logic mid_loss;
    logic oper_loss;
    logic loss_restart;
    logic loss_lock;
    logic s1_fail;
    logic s1_restart;
    logic s1_lock;
    logic do_restart;
    logic stray30;
    logic stray_sb;
    logic sb_expired;
    logic test_done;
    logic test_fail;
    logic comb_bad;
    logic analog_low;
    logic lock_req;
    logic [7:0] lock_code;
    logic analog_mode;
    logic load_live;
    logic [7:0] disp_sel;

    // ----------------------------------------
    // Timing and channel filters
    // ----------------------------------------
    ms_tick #(
        .CYCLES(MS_CYCLES)
    ) u_tick (
        .clk_i(MCLK_I),
        .rst_i(RESET_I),
        .tick_o(tick)
    );

    flame_out_filter #(
        .BASE_MS(flame_pkg::IONIZATION_OUT_MS)
    ) u_ion_filter (
        .clk_i(MCLK_I),
        .rst_i(RESET_I),
        .tick_i(tick),
        .raw_i(IONIZATION_FLAME_I),
        .ext_ms_i(EXT_DELAY_MS_I),
        .flame_o(ion_fl)
    );

    flame_out_filter #(
        .BASE_MS(flame_pkg::DETECTOR_OUT_MS)
    ) u_det_filter (
        .clk_i(MCLK_I),
        .rst_i(RESET_I),
        .tick_i(tick),
        .raw_i(DET_FLAME_I),
        .ext_ms_i(EXT_DELAY_MS_I),
        .flame_o(det_fl)
    );

    // ----------------------------------------
    // Phase decode
    // ----------------------------------------
    assign in_standby = PHASE_I == flame_pkg::PH_STANDBY;
    assign in_prepurge = PHASE_I == flame_pkg::PH_PREPURGE;
    assign in_stray = PHASE_I == flame_pkg::PH_STRAY;
    assign in_mid = PHASE_I == flame_pkg::PH_INTERVAL ||
                    PHASE_I == flame_pkg::PH_SAFETY2;
    assign in_oper = PHASE_I == flame_pkg::PH_OPERATE;
    assign in_shut = PHASE_I == flame_pkg::PH_SHUTDOWN;
    assign test_region = PHASE_I == flame_pkg::PH_SAFETY1 || in_mid ||
                         in_oper;
    assign end_s1 = phase_prev_ff == flame_pkg::PH_SAFETY1 &&
                    PHASE_I != flame_pkg::PH_SAFETY1;
    assign shut_entry = in_shut && phase_prev_ff != flame_pkg::PH_SHUTDOWN;
    assign heat_fall = heat_prev_ff && !HEAT_REQ_I;
    // A pending restart masks further flame events until the sequencer
    // has actually started over, so one loss gives one restart.
    assign live = !LOCKOUT_O && !pend_ff;

    // ----------------------------------------
    // Flame combination
    // ----------------------------------------
    assign raw_any = IONIZATION_FLAME_I | DET_FLAME_I;
    assign any_fl = ion_fl | det_fl;
    assign both_fl = ion_fl & det_fl;
    assign need_both = COMBINE_AND_I && in_oper;
    assign flame_short = need_both ? !both_fl : !any_fl;
    // The end of the first safety time is judged by the s1 path alone,
    // so that a permitted restart is not overtaken by a lockout.
    assign mid_loss = live && in_mid && !any_fl && !end_s1;
    assign oper_loss = live && in_oper && flame_short && !end_s1;

    // ----------------------------------------
    // Restart limiting
    // ----------------------------------------
    assign allow = flame_pkg::restart_allow(RESTART_SET_I);
    assign can_restart = used_ff < allow;
    assign loss_restart = oper_loss && can_restart;
    assign loss_lock = oper_loss && !can_restart;
    assign s1_fail = live && end_s1 && !any_fl;
    assign s1_restart = s1_fail && !from_loss_ff && can_restart;
    assign s1_lock = s1_fail && !s1_restart;
    assign do_restart = loss_restart | s1_restart;

    // ----------------------------------------
    // Extraneous light, self-test, configuration faults
    // ----------------------------------------
    assign stray30 = !LOCKOUT_O && in_stray && raw_any;
    assign stray_sb = in_standby && raw_any;
    // Tolerance of zero locks out on the first cycle of light
    assign sb_expired = !LOCKOUT_O && stray_sb &&
                        sb_sec_ff >= TOLERANCE_S_I;
    assign test_done = tst_ff == flame_pkg::TST_RUN && tick &&
                       tst_ms_ff == flame_pkg::SELFTEST_MS_LAST;
    assign test_fail = !LOCKOUT_O && test_done && DET_FAULT_I;
    assign comb_bad = !LOCKOUT_O &&
                      COMB_MODE_I == flame_pkg::COMB_UNUSED;
    assign analog_low = !LOCKOUT_O && in_oper && ANALOG_LOW_I &&
                        ANALOG_SEL_I == flame_pkg::AIN_4_20_LOCK;

    assign lock_req = test_fail | stray30 | sb_expired | s1_lock |
                      mid_loss | loss_lock | comb_bad | analog_low;
    // Self-test first, so a shutdown fault always reports its own code
    assign lock_code = test_fail ? flame_pkg::LOC_SELFTEST :
                       (stray30 | sb_expired) ? flame_pkg::LOC_STRAY :
                       (s1_lock | mid_loss) ? flame_pkg::LOC_NO_FLAME :
                       loss_lock ? (need_both ? flame_pkg::LOC_AND :
                                    flame_pkg::LOC_NO_FLAME) :
                       comb_bad ? flame_pkg::LOC_COMB :
                       flame_pkg::LOC_ANALOG;

    // ----------------------------------------
    // Load input selection and display
    // ----------------------------------------
    assign load_live = in_oper && !LOCKOUT_O;
    assign analog_mode = ANALOG_SEL_I != flame_pkg::AIN_STEP &&
                         ANALOG_SEL_I <= flame_pkg::AIN_LAST;
    assign disp_sel = DISPLAY_MODE_I == flame_pkg::DISP_IONIZATION ?
                      IONIZATION_LEVEL_I :
                      DISPLAY_MODE_I == flame_pkg::DISP_DETECTOR ?
                      DET_LEVEL_I :
                      DISPLAY_MODE_I == flame_pkg::DISP_POWER ?
                      POWER_I : PHASE_I;

    // ----------------------------------------
    // Self-test state machine
    // ----------------------------------------
    always_comb begin
        nxt_tst = tst_ff;
        case (tst_ff)
            flame_pkg::TST_IDLE: begin
                if (shut_entry) begin
                    nxt_tst = flame_pkg::TST_RUN;
                end
            end
            flame_pkg::TST_RUN: begin
                if (!in_shut) begin
                    nxt_tst = flame_pkg::TST_IDLE;
                end else if (test_done) begin
                    nxt_tst = flame_pkg::TST_DONE;
                end
            end
            flame_pkg::TST_DONE: begin
                if (!in_shut) begin
                    nxt_tst = flame_pkg::TST_IDLE;
                end
            end
            default: begin
                nxt_tst = flame_pkg::TST_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            tst_ff <= flame_pkg::TST_IDLE;
            tst_ms_ff <= 7'h00;
        end else begin
            tst_ff <= nxt_tst;
            if (tst_ff != flame_pkg::TST_RUN) begin
                tst_ms_ff <= 7'h00;
            end else if (tick) begin
                tst_ms_ff <= tst_ms_ff + 7'h01;
            end
        end
    end

    // ----------------------------------------
    // Sequence tracking and restart bookkeeping
    // ----------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            phase_prev_ff <= flame_pkg::PH_STANDBY;
            heat_prev_ff <= 1'b0;
            used_ff <= 2'h0;
            from_loss_ff <= 1'b0;
            pend_ff <= 1'b0;
        end else begin
            phase_prev_ff <= PHASE_I;
            heat_prev_ff <= HEAT_REQ_I;
            // A restart in the same cycle as the heat drop still counts
            if (do_restart) begin
                used_ff <= used_ff + 2'h1;
            end else if (heat_fall) begin
                used_ff <= 2'h0;
            end
            if (loss_restart) begin
                from_loss_ff <= 1'b1;
            end else if (heat_fall || (end_s1 && any_fl)) begin
                from_loss_ff <= 1'b0;
            end
            if (do_restart) begin
                pend_ff <= 1'b1;
            end else if (in_standby || in_prepurge) begin
                pend_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Standby extraneous light timer
    // ----------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (RESET_I || !stray_sb) begin
            sb_ms_ff <= 10'h000;
            sb_sec_ff <= 11'h000;
        end else if (tick) begin
            if (sb_ms_ff == flame_pkg::MS_PER_S_LAST) begin
                sb_ms_ff <= 10'h000;
                if (sb_sec_ff != 11'h7ff) begin
                    sb_sec_ff <= sb_sec_ff + 11'h001;
                end
            end else begin
                sb_ms_ff <= sb_ms_ff + 10'h001;
            end
        end
    end

    // ----------------------------------------
    // Lockout and outputs
    // ----------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            LOCKOUT_O <= 1'b0;
            LOCK_CODE_O <= 8'h00;
        end else if (lock_req) begin
            LOCKOUT_O <= 1'b1;
            LOCK_CODE_O <= lock_code;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            DET_TEST_O <= 1'b0;
            RESTART_O <= 1'b0;
            STRAY_LED_O <= 1'b0;
            STANDBY_STRAY_LIGHT_INDICATION_O <= 1'b0;
            DISPLAY_O <= 8'h00;
        end else begin
            // Inactive in prepurge and during the shutdown self-test
            DET_TEST_O <= !LOCKOUT_O && test_region;
            RESTART_O <= do_restart;
            STRAY_LED_O <= stray_sb;
            STANDBY_STRAY_LIGHT_INDICATION_O <= stray_sb;
            DISPLAY_O <= disp_sel;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            LOAD_DOWN_O <= 1'b0;
            LOAD_UP_O <= 1'b0;
            LOAD_VALUE_O <= 12'h000;
            LOAD_VALID_O <= 1'b0;
        end else begin
            LOAD_DOWN_O <= load_live && !analog_mode && LOAD_CLOSE_I;
            LOAD_UP_O <= load_live && !analog_mode && LOAD_OPEN_I;
            LOAD_VALID_O <= load_live && analog_mode;
            if (load_live && analog_mode) begin
                LOAD_VALUE_O <= ANALOG_VALUE_I;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_prepurge_test;
        @(posedge MCLK_I) disable iff (RESET_I)
        in_prepurge |=> !DET_TEST_O;
    endproperty
    a_prepurge_test: assert property (p_prepurge_test)
        else $error("test output active in prepurge");

    property p_operate_test;
        @(posedge MCLK_I) disable iff (RESET_I)
        (in_oper && !LOCKOUT_O) [*2] |=> DET_TEST_O;
    endproperty
    a_operate_test: assert property (p_operate_test)
        else $error("test output inactive in operation");

    property p_selftest;
        @(posedge MCLK_I) disable iff (RESET_I)
        test_done && DET_FAULT_I && !LOCKOUT_O |=>
            LOCKOUT_O && LOCK_CODE_O == flame_pkg::LOC_SELFTEST;
    endproperty
    a_selftest: assert property (p_selftest)
        else $error("self-test fault did not lock with 31");

    property p_restart_limit;
        @(posedge MCLK_I) disable iff (RESET_I)
        RESTART_O |-> $past(used_ff) < $past(allow);
    endproperty
    a_restart_limit: assert property (p_restart_limit)
        else $error("restart beyond the allowed count");

    property p_loss_restart_lock;
        @(posedge MCLK_I) disable iff (RESET_I)
        s1_fail && from_loss_ff |=> LOCKOUT_O && !RESTART_O;
    endproperty
    a_loss_restart_lock: assert property (p_loss_restart_lock)
        else $error("no flame after loss restart did not lock");

    property p_and_lock;
        @(posedge MCLK_I) disable iff (RESET_I)
        live && in_oper && COMBINE_AND_I && !both_fl && !end_s1 &&
            !can_restart |=> LOCK_CODE_O == flame_pkg::LOC_AND;
    endproperty
    a_and_lock: assert property (p_and_lock)
        else $error("single channel loss in AND mode not code 7");

    property p_stray30;
        @(posedge MCLK_I) disable iff (RESET_I)
        in_stray && raw_any && !LOCKOUT_O |=>
            LOCKOUT_O && LOCK_CODE_O == flame_pkg::LOC_STRAY;
    endproperty
    a_stray30: assert property (p_stray30)
        else $error("light in phase 30 did not lock with 4");

    property p_standby_led;
        @(posedge MCLK_I) disable iff (RESET_I)
        stray_sb |=> STRAY_LED_O && STANDBY_STRAY_LIGHT_INDICATION_O;
    endproperty
    a_standby_led: assert property (p_standby_led)
        else $error("standby light not indicated");

    property p_load_ignored;
        @(posedge MCLK_I) disable iff (RESET_I)
        !in_oper |=> !LOAD_UP_O && !LOAD_DOWN_O && !LOAD_VALID_O;
    endproperty
    a_load_ignored: assert property (p_load_ignored)
        else $error("load input acted on outside operation");

endmodule: flame_supervision_logic

// File: verification/flame_detectors.sv
// Model of the two flame detectors at the far side of the block.
// Assumes the bench sets flame presence and fault, and the block its test.
`timescale 1ns/1ps
module flame_detectors (
    input wire logic ion_on_i,
    input wire logic det_on_i,
    input wire logic fault_i,
    input wire logic test_run_i,
    output logic ion_o,
    output logic det_o,
    output logic fault_o
);
    // Detector shows flame only while the block holds its test output active
    assign ion_o = ion_on_i;
    assign det_o = det_on_i & test_run_i;
    assign fault_o = fault_i;
endmodule: flame_detectors

// File: verification/tb_flame_supervision_logic.sv
// Self-checking bench for the flame supervision block.
// Assumes a 10-cycle millisecond so that second-long counts stay short.
`timescale 1ns/1ps
module tb_flame_supervision_logic;
    localparam logic [7:0] SB = flame_pkg::PH_STANDBY;
    localparam logic [7:0] S1 = flame_pkg::PH_SAFETY1;
    localparam logic [7:0] OP = flame_pkg::PH_OPERATE;
    logic clk, rst, heat, ion_on, det_on, fault, cand, low, lcl, lop;
    logic ionization_channel, det, dflt, tst, lock, rs_o, led, ind, ldn, lup, lv;
    logic [7:0] phase, code, disp;
    logic [2:0] rset, asel, dmode;
    logic [10:0] tol;
    logic [1:0] cmode;
    logic [11:0] lval, ext;
    logic [7:0] dexp [4] = '{8'h3c, 8'h5a, 8'ha5, 8'h77};
    int fails, n_checks, k, n;

    flame_detectors partner (.ion_on_i(ion_on), .det_on_i(det_on),
        .fault_i(fault), .test_run_i(tst), .ion_o(ionization_channel), .det_o(det),
        .fault_o(dflt));
    flame_supervision_logic #(.MS_CYCLES(10)) DUT (.MCLK_I(clk),
        .RESET_I(rst), .PHASE_I(phase), .HEAT_REQ_I(heat),
        .IONIZATION_FLAME_I(ionization_channel), .DET_FLAME_I(det), .DET_FAULT_I(dflt),
        .COMBINE_AND_I(cand), .RESTART_SET_I(rset),
        .EXT_DELAY_MS_I(ext), .TOLERANCE_S_I(tol),
        .COMB_MODE_I(cmode), .ANALOG_SEL_I(asel),
        .ANALOG_VALUE_I(12'h0123), .ANALOG_LOW_I(low), .LOAD_CLOSE_I(lcl),
        .LOAD_OPEN_I(lop), .DISPLAY_MODE_I(dmode),
        .IONIZATION_LEVEL_I(8'h5a), .DET_LEVEL_I(8'ha5), .POWER_I(8'h77),
        .DET_TEST_O(tst), .LOCKOUT_O(lock), .LOCK_CODE_O(code),
        .RESTART_O(rs_o), .STRAY_LED_O(led),
        .STANDBY_STRAY_LIGHT_INDICATION_O(ind), .LOAD_DOWN_O(ldn),
        .LOAD_UP_O(lup), .LOAD_VALUE_O(lval), .LOAD_VALID_O(lv),
        .DISPLAY_O(disp));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [11:0] e, g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", what, e, g);
        end
    endtask: chk

    task automatic go(input logic [7:0] p, input int c);
        @(negedge clk);
        phase = p;
        repeat (c) @(negedge clk);
    endtask: go

    // Every test starts from a fresh reset with no flame and defaults
    task automatic rs();
        {rst, heat, ion_on, det_on, fault, cand, low, lcl, lop} = 9'h180;
        {phase, rset, asel, dmode} = {SB, 3'h0, 3'h0, 3'h1};
        cmode = 2'h0;
        ext = 12'h000;
        tol = flame_pkg::TOLERANCE_DEFAULT_S;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
    endtask: rs

    // Brings the burner into operation on the ionization flame
    task automatic run_up();
        go(S1, 0);
        ion_on = 1'b1;
        go(S1, 2);
        go(flame_pkg::PH_SAFETY2, 2);
        go(OP, 2);
    endtask: run_up

    // One start without flame: standby, first safety time, then interval
    task automatic attempt();
        go(SB, 1);
        go(S1, 1);
        go(flame_pkg::PH_INTERVAL, 0);
        repeat (3) @(negedge clk) if (rs_o === 1'b1) n++;
    endtask: attempt

    task automatic final_report();
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask: final_report

    initial begin
        fails = 0;
        n_checks = 0;
        rs();
        chk("lock", 0, lock);
        go(flame_pkg::PH_PREPURGE, 2);
        chk("test", 0, tst);
        go(flame_pkg::PH_STRAY, 0);
        ion_on = 1'b1;
        go(flame_pkg::PH_STRAY, 1);
        chk("code", {4'h1, flame_pkg::LOC_STRAY}, {lock, code});
        rs();
        run_up();
        chk("test", 1, tst);
        fault = 1'b1;
        go(flame_pkg::PH_SHUTDOWN, 1100);
        chk("code", 12'h11f, {lock, code});
        rs();
        cmode = flame_pkg::COMB_UNUSED;
        go(SB, 3);
        chk("code", 12'h10f, {lock, code});
        rs();
        ion_on = 1'b1;
        go(SB, 2);
        chk("led", 2'h3, {led, ind});
        repeat (10500) @(negedge clk);
        chk("lock", 0, lock);
        tol = 11'h001;
        go(SB, 2);
        chk("code", 12'h104, {lock, code});
        // Count restarts granted by each setting before lockout
        for (int s = 0; s < 5; s++) begin
            rs();
            rset = s[2:0];
            n = 0;
            for (int a = 0; a < 5 && !lock; a++) begin
                attempt();
            end
            chk("restarts", (s < 2) ? 0 : s - 1, n);
            chk("code", 12'h102, {lock, code});
        end
        // Dropping the heat request gives back the full allowance
        rs();
        rset = 3'h2;
        n = 0;
        attempt();
        heat = 1'b0;
        attempt();
        chk("restarts", 2, n);
        chk("lock", 0, lock);
        rs();
        rset = 3'h3;
        ext = 12'h00a;
        run_up();
        ion_on = 1'b0;
        for (k = 0; k < 12000 && rs_o !== 1'b1; k++) @(negedge clk);
        chk("restart", 1, rs_o);
        // 1000 ms base plus 10 ms extension at 10 cycles per ms
        chk("late", 1, k >= 10050 && k <= 10150);
        go(SB, 1);
        go(S1, 1);
        go(flame_pkg::PH_INTERVAL, 3);
        chk("code", 12'h102, {lock, code});
        rs();
        {cand, det_on} = 2'b11;
        run_up();
        ion_on = 1'b0;
        for (k = 0; k < 12000 && lock !== 1'b1; k++) @(negedge clk);
        chk("code", 12'h107, {lock, code});
        rs();
        run_up();
        lcl = 1'b1;
        go(OP, 2);
        chk("down", 2'h2, {ldn, lup});
        asel = 3'h1;
        go(OP, 2);
        chk("value", 12'h123, lval);
        chk("valid", 1, lv);
        for (int m = 0; m < 4; m++) begin
            dmode = 3'(m + 1);
            go(OP, 2);
            chk("display", {4'h0, dexp[m]}, disp);
        end
        asel = flame_pkg::AIN_4_20_LOCK;
        low = 1'b1;
        go(OP, 2);
        chk("code", 12'h13c, {lock, code});
        chk("valid", 0, lv);
        final_report();
    end

    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule: tb_flame_supervision_logic
